// >>> logic/pwit_regs.v
// per-port default tag, wake-on-lan and port interrupt registers, AXI4-Lite slave
// assumes: event and interrupt inputs come from switch logic on clk_sys, events are pulses
//
// Register access over AXI4-Lite was chosen for this implementation.
`include "pwit_consts.vh"

module pwit_regs (
    input  wire        clk_sys,
    input  wire        reset,
    input  wire [17:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [17:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [47:0] switch_mac_addr,
    input  wire        magic_pkt_valid,
    input  wire [2:0]  magic_pkt_port,
    input  wire [47:0] magic_pkt_dest,
    input  wire [6:0]  link_up_pulse,
    input  wire [6:0]  energy_pulse,
    input  wire [6:0]  ptp_irq_pending,
    input  wire [6:0]  phy_irq_pending,
    input  wire [6:0]  acl_irq_pulse,
    output reg         wake_event_out,
    output reg  [6:0]  port_irq_req,
    output reg         irq
);

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    localparam [6:0] PHY_PORTS = `PWIT_PHY_PORTS;
    // returns {hit, selector}
    function [3:0] reg_decode;
        input [17:0] addr;
        reg   [3:0]  port;
        reg   [11:0] off;
        begin
            port = addr[17:14];
            off  = addr[13:2];
            reg_decode = 4'h0;
            if (port == 4'h0) begin
                if (off == `PWIT_OFF_BLK_STATUS)
                    reg_decode = {1'b1, `PWIT_SEL_BLK_STATUS};
                else if (off == `PWIT_OFF_BLK_ENABLE)
                    reg_decode = {1'b1, `PWIT_SEL_BLK_ENABLE};
            end else if (port >= `PWIT_PORT_FIRST && port <= `PWIT_PORT_LAST) begin
                case (off)
                    `PWIT_OFF_TAG_HIGH:    reg_decode = {1'b1, `PWIT_SEL_TAG_HIGH};
                    `PWIT_OFF_TAG_LOW:     reg_decode = {1'b1, `PWIT_SEL_TAG_LOW};
                    `PWIT_OFF_WAKE_EVENT:  reg_decode = {1'b1, `PWIT_SEL_WAKE_EVENT};
                    `PWIT_OFF_WAKE_ENABLE: reg_decode = {1'b1, `PWIT_SEL_WAKE_ENABLE};
                    `PWIT_OFF_IRQ_STATUS:  reg_decode = {1'b1, `PWIT_SEL_IRQ_STATUS};
                    `PWIT_OFF_IRQ_MASK:    reg_decode = {1'b1, `PWIT_SEL_IRQ_MASK};
                    default:               reg_decode = 4'h0;
                endcase
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    reg [7:0]  tag_high       [1:7];
    reg [7:0]  tag_low        [1:7];
    reg [2:0]  wake_event     [1:7];
    reg [2:0]  wake_enable    [1:7];
    reg        acl_status     [1:7];
    reg [2:0]  irq_mask       [1:7];
    reg [7:0]  next_tag_high  [1:7];
    reg [7:0]  next_tag_low   [1:7];
    reg [2:0]  next_wake_event[1:7];
    reg [2:0]  next_wake_enable[1:7];
    reg        next_acl_status[1:7];
    reg [2:0]  next_irq_mask  [1:7];
    reg [3:0]  blk_status;
    reg [3:0]  blk_enable;
    reg [3:0]  next_blk_status;
    reg [3:0]  next_blk_enable;

    reg        aw_held;
    reg        w_held;
    reg [17:0] aw_addr_q;
    reg [7:0]  w_data_q;
    reg        w_lane0_q;

    reg        next_wake;
    reg [6:0]  next_port_irq;
    reg [31:0] next_rdata;
    reg [1:0]  next_rresp;
    reg [3:0]  ev_sum;

    wire       wr_do   = aw_held & w_held & ~s_axi_bvalid;
    wire [3:0] wr_dec  = reg_decode(aw_addr_q);
    wire [2:0] wr_port = aw_addr_q[16:14];
    wire       wr_ok   = wr_do & wr_dec[3] & w_lane0_q;
    wire       rd_do   = s_axi_arvalid & s_axi_arready;
    wire [3:0] rd_dec  = reg_decode(s_axi_araddr);
    wire [2:0] rd_port = s_axi_araddr[16:14];
    wire       magic_hit = magic_pkt_valid && (magic_pkt_dest == switch_mac_addr);

    // ------------------------------------------------------------------------
    // per-port current status view
    // ------------------------------------------------------------------------
    function [2:0] port_status;
        input [2:0] p;
        input       ptp;
        input       phy;
        input       acl;
        reg         is_phy;
        begin
            is_phy = PHY_PORTS[p - 3'd1];
            port_status = 3'h0;
            port_status[`PWIT_IRQ_PTP] = ptp & is_phy;
            port_status[`PWIT_IRQ_PHY] = phy & is_phy;
            port_status[`PWIT_IRQ_ACL] = acl;
        end
    endfunction

    // ------------------------------------------------------------------------
    // next state of the register file
    // ------------------------------------------------------------------------
    integer p;
    integer q;
    always @* begin
        next_wake     = 1'b0;
        next_port_irq = 7'h00;
        ev_sum        = 4'h0;
        for (p = 1; p <= 7; p = p + 1) begin
            next_tag_high[p]    = tag_high[p];
            next_tag_low[p]     = tag_low[p];
            next_wake_event[p]  = wake_event[p];
            next_wake_enable[p] = wake_enable[p];
            next_acl_status[p]  = acl_status[p];
            next_irq_mask[p]    = irq_mask[p];
            // software side first, so hardware sets below win over clears
            if (wr_ok && wr_port == p[2:0]) begin
                case (wr_dec[2:0])
                    `PWIT_SEL_TAG_HIGH:    next_tag_high[p] = w_data_q;
                    `PWIT_SEL_TAG_LOW:     next_tag_low[p]  = w_data_q;
                    `PWIT_SEL_WAKE_EVENT:
                        next_wake_event[p] = wake_event[p] & ~w_data_q[2:0];
                    `PWIT_SEL_WAKE_ENABLE: next_wake_enable[p] = w_data_q[2:0];
                    `PWIT_SEL_IRQ_MASK: begin
                        next_irq_mask[p] = w_data_q[2:0];
                        if (w_data_q[`PWIT_IRQ_ACL] != irq_mask[p][`PWIT_IRQ_ACL])
                            next_acl_status[p] = 1'b0;
                    end
                    default: ;
                endcase
            end
            if (magic_hit && magic_pkt_port == p[2:0])
                next_wake_event[p][`PWIT_WAKE_MAGIC] = 1'b1;
            if (link_up_pulse[p-1])
                next_wake_event[p][`PWIT_WAKE_LINK] = 1'b1;
            if (energy_pulse[p-1])
                next_wake_event[p][`PWIT_WAKE_ENERGY] = 1'b1;
            if (acl_irq_pulse[p-1])
                next_acl_status[p] = 1'b1;
            if (!PHY_PORTS[p-1]) begin
                next_wake_event[p][1:0]  = 2'b00;
                next_wake_enable[p][1:0] = 2'b00;
            end
            next_wake = next_wake | (|(wake_event[p] & wake_enable[p]));
            next_port_irq[p-1] = |(port_status(p[2:0], ptp_irq_pending[p-1],
                                  phy_irq_pending[p-1], acl_status[p])
                                  & ~irq_mask[p]);
            ev_sum[`PWIT_BLK_MAGIC]  = ev_sum[`PWIT_BLK_MAGIC]
                                     | (magic_hit && magic_pkt_port == p[2:0]);
            ev_sum[`PWIT_BLK_LINK]   = ev_sum[`PWIT_BLK_LINK]
                                     | (link_up_pulse[p-1] & PHY_PORTS[p-1]);
            ev_sum[`PWIT_BLK_ENERGY] = ev_sum[`PWIT_BLK_ENERGY]
                                     | (energy_pulse[p-1] & PHY_PORTS[p-1]);
            ev_sum[`PWIT_BLK_ACL]    = ev_sum[`PWIT_BLK_ACL] | acl_irq_pulse[p-1];
        end
        // block events: read clears, a new event in the same cycle wins
        next_blk_status = blk_status;
        if (rd_do && rd_dec == {1'b1, `PWIT_SEL_BLK_STATUS})
            next_blk_status = 4'h0;
        next_blk_status = next_blk_status | ev_sum;
        next_blk_enable = blk_enable;
        if (wr_ok && wr_port == 3'd0 && wr_dec[2:0] == `PWIT_SEL_BLK_ENABLE)
            next_blk_enable = w_data_q[3:0];
    end

    // ------------------------------------------------------------------------
    // read data mux
    // ------------------------------------------------------------------------
    always @* begin
        next_rdata = 32'h0000_0000;
        next_rresp = `PWIT_RESP_OKAY;
        if (!rd_dec[3]) begin
            next_rresp = `PWIT_RESP_SLVERR;
        end else begin
            case (rd_dec[2:0])
                `PWIT_SEL_TAG_HIGH:    next_rdata[7:0] = tag_high[rd_port];
                `PWIT_SEL_TAG_LOW:     next_rdata[7:0] = tag_low[rd_port];
                `PWIT_SEL_WAKE_EVENT:  next_rdata[2:0] = wake_event[rd_port];
                `PWIT_SEL_WAKE_ENABLE: next_rdata[2:0] = wake_enable[rd_port];
                `PWIT_SEL_IRQ_STATUS:
                    next_rdata[2:0] = port_status(rd_port, ptp_irq_pending[rd_port-3'd1],
                                                  phy_irq_pending[rd_port-3'd1],
                                                  acl_status[rd_port]);
                `PWIT_SEL_IRQ_MASK:    next_rdata[2:0] = irq_mask[rd_port];
                `PWIT_SEL_BLK_STATUS:  next_rdata[3:0] = blk_status;
                `PWIT_SEL_BLK_ENABLE:  next_rdata[3:0] = blk_enable;
                default:               next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // registers and bus handshakes
    // ------------------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (reset) begin
            for (q = 1; q <= 7; q = q + 1) begin
                tag_high[q]    <= `PWIT_RST_TAG_HIGH;
                tag_low[q]     <= `PWIT_RST_TAG_LOW;
                wake_event[q]  <= 3'h0;
                wake_enable[q] <= 3'h0;
                acl_status[q]  <= 1'b0;
                irq_mask[q]    <= 3'h0;
            end
            blk_status     <= 4'h0;
            blk_enable     <= 4'h0;
            aw_held        <= 1'b0;
            w_held         <= 1'b0;
            aw_addr_q      <= 18'h00000;
            w_data_q       <= 8'h00;
            w_lane0_q      <= 1'b0;
            s_axi_awready  <= 1'b1;
            s_axi_wready   <= 1'b1;
            s_axi_bvalid   <= 1'b0;
            s_axi_bresp    <= `PWIT_RESP_OKAY;
            s_axi_arready  <= 1'b1;
            s_axi_rvalid   <= 1'b0;
            s_axi_rdata    <= 32'h0000_0000;
            s_axi_rresp    <= `PWIT_RESP_OKAY;
            wake_event_out <= 1'b0;
            port_irq_req   <= 7'h00;
            irq            <= 1'b0;
        end else begin
            for (q = 1; q <= 7; q = q + 1) begin
                tag_high[q]    <= next_tag_high[q];
                tag_low[q]     <= next_tag_low[q];
                wake_event[q]  <= next_wake_event[q];
                wake_enable[q] <= next_wake_enable[q];
                acl_status[q]  <= next_acl_status[q];
                irq_mask[q]    <= next_irq_mask[q];
            end
            blk_status     <= next_blk_status;
            blk_enable     <= next_blk_enable;
            wake_event_out <= next_wake;
            port_irq_req   <= next_port_irq;
            irq            <= |(blk_status & blk_enable);
            // write address and data are taken in either order
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_addr_q     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_data_q     <= s_axi_wdata[7:0];
                w_lane0_q    <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_dec[3] ? `PWIT_RESP_OKAY : `PWIT_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_held       <= 1'b0;
                w_held        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (rd_do) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= next_rdata;
                s_axi_rresp   <= next_rresp;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // pwit_regs

// >>> logic/pwit_consts.vh
// offsets, field positions, reset values and codes of the port wake/irq/tag registers
// assumes: includer uses the AXI4-Lite byte address bits [17:2] as the register index
`ifndef PWIT_CONSTS_VH
`define PWIT_CONSTS_VH

// ----------------------------------------------------------------------------
// register index, low twelve bits; bits [15:12] of the index carry the port
// ----------------------------------------------------------------------------
`define PWIT_OFF_TAG_HIGH    12'h000
`define PWIT_OFF_TAG_LOW     12'h001
`define PWIT_OFF_WAKE_EVENT  12'h013
`define PWIT_OFF_WAKE_ENABLE 12'h017
`define PWIT_OFF_IRQ_STATUS  12'h01b
`define PWIT_OFF_IRQ_MASK    12'h01f
// block level event status and enable, on port nibble zero
`define PWIT_OFF_BLK_STATUS  12'h000
`define PWIT_OFF_BLK_ENABLE  12'h001

// ----------------------------------------------------------------------------
// ports and reset values
// ----------------------------------------------------------------------------
`define PWIT_PORT_FIRST      4'h1
`define PWIT_PORT_LAST       4'h7
`define PWIT_PHY_PORTS       7'h1f
`define PWIT_RST_TAG_HIGH    8'h00
`define PWIT_RST_TAG_LOW     8'h01

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define PWIT_WAKE_MAGIC      2
`define PWIT_WAKE_LINK       1
`define PWIT_WAKE_ENERGY     0
`define PWIT_IRQ_PTP         2
`define PWIT_IRQ_PHY         1
`define PWIT_IRQ_ACL         0
`define PWIT_BLK_MAGIC       0
`define PWIT_BLK_LINK        1
`define PWIT_BLK_ENERGY      2
`define PWIT_BLK_ACL         3

// ----------------------------------------------------------------------------
// register selector codes and bus responses
// ----------------------------------------------------------------------------
`define PWIT_SEL_TAG_HIGH    3'h0
`define PWIT_SEL_TAG_LOW     3'h1
`define PWIT_SEL_WAKE_EVENT  3'h2
`define PWIT_SEL_WAKE_ENABLE 3'h3
`define PWIT_SEL_IRQ_STATUS  3'h4
`define PWIT_SEL_IRQ_MASK    3'h5
`define PWIT_SEL_BLK_STATUS  3'h6
`define PWIT_SEL_BLK_ENABLE  3'h7
`define PWIT_RESP_OKAY       2'h0
`define PWIT_RESP_SLVERR     2'h2

`endif

// >>> bench/pwit_regs_properties.sv
// pwit_regs_properties: handshake and event-cause assertions for the port register bank
// assumes: bound to pwit_regs, one clk_sys domain, synchronous active-high reset
`include "pwit_consts.vh"
module pwit_regs_properties (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        magic_pkt_valid,
    input wire logic [6:0]  link_up_pulse,
    input wire logic [6:0]  energy_pulse,
    input wire logic [6:0]  acl_irq_pulse,
    input wire logic        wake_event_out,
    input wire logic [6:0]  port_irq_req,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bv_q;
    // a write answer just appeared: the only bus cause for an output to rise
    wire  wr_new  = s_axi_bvalid & ~bv_q;
    wire  ev_any  = magic_pkt_valid | (|link_up_pulse) | (|energy_pulse);
    wire  blk_ev  = ev_any | (|acl_irq_pulse);
    wire  acl_mac = |acl_irq_pulse[6:5];
    always @(posedge clk_sys) begin
        bv_q <= reset ? 1'b0 : s_axi_bvalid;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence r_answer;
        s_axi_rvalid && !s_axi_arready;
    endsequence
    sequence w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    chk_read_answer: assert property (ar_taken |=> r_answer)
        else $error("read answer not one cycle after address");
    chk_write_answer: assert property (w_taken |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer dropped or changed");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    chk_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while answer pending");
    chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_slverr_data: assert property (s_axi_rvalid && s_axi_rresp == `PWIT_RESP_SLVERR
        |-> s_axi_rdata == 32'h0) else $error("error read returned data");
    chk_wake_cause: assert property ($rose(wake_event_out) |->
        $past(ev_any, 2) || $past(wr_new)) else $error("wake output rose without cause");
    chk_mac_irq: assert property ($rose(port_irq_req[5]) || $rose(port_irq_req[6])
        |-> $past(acl_mac, 2) || $past(wr_new)) else $error("mac port request without cause");
    chk_irq_cause: assert property ($rose(irq) |-> $past(blk_ev, 2) || $past(wr_new))
        else $error("interrupt rose without cause");
endmodule // pwit_regs_properties

bind pwit_regs pwit_regs_properties u_chk (.clk_sys(clk_sys), .reset(reset),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .magic_pkt_valid(magic_pkt_valid),
    .link_up_pulse(link_up_pulse), .energy_pulse(energy_pulse), .acl_irq_pulse(acl_irq_pulse),
    .wake_event_out(wake_event_out), .port_irq_req(port_irq_req), .irq(irq));

// >>> bench/pwit_regs_tb.sv
// pwit_regs_tb: self-checking bench for the port tag, wake and interrupt registers
// assumes: pwit_consts.vh on the include path, checker bound from its own file
`include "pwit_consts.vh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module pwit_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, magic_pkt_valid;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic [2:0]  magic_pkt_port;
    logic [47:0] switch_mac_addr, magic_pkt_dest;
    logic [6:0]  link_up_pulse, energy_pulse, ptp_irq_pending, phy_irq_pending, acl_irq_pulse;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire         wake_event_out, irq;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [6:0]  port_irq_req;
    integer      seed, n_mismatch, check_count, p;
    logic [1:0]  r;
    logic [7:0]  v, tag_h [1:7], tag_l [1:7];
    pwit_regs DUT (.clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .switch_mac_addr, .magic_pkt_valid,
        .magic_pkt_port, .magic_pkt_dest, .link_up_pulse, .energy_pulse, .ptp_irq_pending,
        .phy_irq_pending, .acl_irq_pulse, .wake_event_out, .port_irq_req, .irq);
    // ------------------------------------------------------------------------
    // bus tasks and expectations
    // ------------------------------------------------------------------------
    function automatic [17:0] ad(input [3:0] pt, input [11:0] off);
        ad = {pt, off, 2'b00};
    endfunction
    // ports 6 and 7 have no phy: only the bits in keep survive there
    function automatic [7:0] phy_only(input integer pt, input [7:0] x, input [7:0] keep);
        phy_only = (pt <= 5) ? x : (x & keep);
    endfunction
    task automatic wr(input [17:0] a, input [7:0] d, output [1:0] resp);
        bit a_ok, w_ok, done;
        a_ok = 0;
        w_ok = 0;
        done = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge clk_sys);
            if (!a_ok && s_axi_awready) begin
                a_ok = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid) begin
                done = 1;
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
            end
        end
    endtask
    task automatic rd(input [17:0] a, output [7:0] d, output [1:0] resp);
        bit a_ok, done;
        a_ok = 0;
        done = 0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge clk_sys);
            if (!a_ok && s_axi_arready) begin
                a_ok = 1;
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid) begin
                done = 1;
                d = s_axi_rdata[7:0];
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
            end
        end
    endtask
    task automatic rd_chk(input [17:0] a, input [7:0] e, input [1:0] er);
        logic [7:0] d;
        logic [1:0] rr;
        rd(a, d, rr);
        `CHK("rdata", e, d)
        `CHK("rresp", er, rr)
    endtask
    // one-cycle event pulse on the switch side
    task automatic ev(input [6:0] lk, input [6:0] en, input [6:0] ac, input mv,
                      input [2:0] mp, input [47:0] md);
        @(posedge clk_sys);
        link_up_pulse <= lk;
        energy_pulse <= en;
        acl_irq_pulse <= ac;
        magic_pkt_valid <= mv;
        magic_pkt_port <= mp;
        magic_pkt_dest <= md;
        @(posedge clk_sys);
        {link_up_pulse, energy_pulse, acl_irq_pulse, magic_pkt_valid} <= 22'h0;
    endtask
    task automatic settle;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic wrap_up;
        if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ------------------------------------------------------------------------
    // clock, watchdog and scenarios
    // ------------------------------------------------------------------------
    initial begin
        clk_sys = 0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        wrap_up;
    end
    initial begin
        seed = 17924;
        n_mismatch = 0;
        check_count = 0;
        reset = 1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        s_axi_awaddr = 18'h0;
        s_axi_araddr = 18'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'h1;
        {magic_pkt_valid, magic_pkt_port, magic_pkt_dest} = 52'h0;
        {link_up_pulse, energy_pulse, ptp_irq_pending, phy_irq_pending, acl_irq_pulse} = 35'h0;
        switch_mac_addr = {$random(seed), $random(seed)};
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        for (p = 1; p <= 7; p++) begin
            tag_h[p] = 8'h00;
            tag_l[p] = 8'h01;
            rd_chk(ad(p, `PWIT_OFF_TAG_HIGH), 8'h00, `PWIT_RESP_OKAY);
            rd_chk(ad(p, `PWIT_OFF_TAG_LOW), 8'h01, `PWIT_RESP_OKAY);
            rd_chk(ad(p, `PWIT_OFF_IRQ_MASK), 8'h00, `PWIT_RESP_OKAY);
        end
        repeat (10) begin
            p = 1 + ($unsigned($random(seed)) % 7);
            tag_h[p] = $random(seed);
            tag_l[p] = $random(seed);
            wr(ad(p, `PWIT_OFF_TAG_HIGH), tag_h[p], r);
            wr(ad(p, `PWIT_OFF_TAG_LOW), tag_l[p], r);
        end
        for (p = 1; p <= 7; p++) begin
            rd_chk(ad(p, `PWIT_OFF_TAG_HIGH), tag_h[p], `PWIT_RESP_OKAY);
            rd_chk(ad(p, `PWIT_OFF_TAG_LOW), tag_l[p], `PWIT_RESP_OKAY);
        end
        wr(ad(3, `PWIT_OFF_IRQ_MASK), 8'hff, r);
        rd_chk(ad(3, `PWIT_OFF_IRQ_MASK), 8'h07, `PWIT_RESP_OKAY);
        wr(ad(3, `PWIT_OFF_IRQ_MASK), 8'h00, r);
        wr(ad(3, `PWIT_OFF_IRQ_STATUS), 8'hff, r);
        rd_chk(ad(3, `PWIT_OFF_IRQ_STATUS), 8'h00, `PWIT_RESP_OKAY);
        rd_chk(ad(4'h8, `PWIT_OFF_TAG_HIGH), 8'h00, `PWIT_RESP_SLVERR);
        wr(ad(4'hf, `PWIT_OFF_TAG_LOW), 8'h5a, r);
        `CHK("bresp", `PWIT_RESP_SLVERR, r)
        ev(7'h0, 7'h0, 7'h0, 1'b1, 3'd2, ~switch_mac_addr);
        rd_chk(ad(2, `PWIT_OFF_WAKE_EVENT), 8'h00, `PWIT_RESP_OKAY);
        ev(7'h0, 7'h0, 7'h0, 1'b1, 3'd2, switch_mac_addr);
        rd_chk(ad(2, `PWIT_OFF_WAKE_EVENT), 8'h04, `PWIT_RESP_OKAY);
        `CHK("wake_event_out", 1'b0, wake_event_out)
        wr(ad(2, `PWIT_OFF_WAKE_ENABLE), 8'h04, r);
        settle;
        `CHK("wake_event_out", 1'b1, wake_event_out)
        wr(ad(2, `PWIT_OFF_WAKE_EVENT), 8'h04, r);
        rd_chk(ad(2, `PWIT_OFF_WAKE_EVENT), 8'h00, `PWIT_RESP_OKAY);
        wr(ad(2, `PWIT_OFF_WAKE_ENABLE), 8'h00, r);
        for (p = 1; p <= 7; p++) begin
            wr(ad(p, `PWIT_OFF_WAKE_ENABLE), 8'h03, r);
            ev(7'h1 << (p - 1), 7'h1 << (p - 1), 7'h0, 1'b0, 3'd0, 48'h0);
            rd_chk(ad(p, `PWIT_OFF_WAKE_EVENT), phy_only(p, 8'h03, 8'h0), 2'h0);
            rd_chk(ad(p, `PWIT_OFF_WAKE_ENABLE), phy_only(p, 8'h03, 8'h0), 2'h0);
            `CHK("wake_event_out", p <= 5, wake_event_out)
            wr(ad(p, `PWIT_OFF_WAKE_EVENT), 8'h07, r);
            wr(ad(p, `PWIT_OFF_WAKE_ENABLE), 8'h00, r);
        end
        ptp_irq_pending <= 7'h42;
        phy_irq_pending <= 7'h44;
        ev(7'h0, 7'h0, 7'h40, 1'b0, 3'd0, 48'h0);
        rd_chk(ad(2, `PWIT_OFF_IRQ_STATUS), 8'h04, `PWIT_RESP_OKAY);
        rd_chk(ad(3, `PWIT_OFF_IRQ_STATUS), 8'h02, `PWIT_RESP_OKAY);
        rd_chk(ad(7, `PWIT_OFF_IRQ_STATUS), 8'h01, `PWIT_RESP_OKAY);
        `CHK("port_irq_req", 7'h46, port_irq_req)
        wr(ad(2, `PWIT_OFF_IRQ_MASK), 8'h04, r);
        settle;
        `CHK("port_irq_req", 7'h44, port_irq_req)
        wr(ad(7, `PWIT_OFF_IRQ_MASK), 8'h01, r);
        wr(ad(7, `PWIT_OFF_IRQ_MASK), 8'h00, r);
        rd_chk(ad(7, `PWIT_OFF_IRQ_STATUS), 8'h00, `PWIT_RESP_OKAY);
        `CHK("port_irq_req", 7'h04, port_irq_req)
        wr(ad(2, `PWIT_OFF_IRQ_MASK), 8'h00, r);
        ptp_irq_pending <= 7'h0;
        phy_irq_pending <= 7'h0;
        settle;
        `CHK("port_irq_req", 7'h00, port_irq_req)
        rd(ad(0, `PWIT_OFF_BLK_STATUS), v, r);
        wr(ad(0, `PWIT_OFF_BLK_ENABLE), 8'h01, r);
        ev(7'h0, 7'h0, 7'h0, 1'b1, 3'd5, switch_mac_addr);
        settle;
        `CHK("irq", 1'b1, irq)
        rd_chk(ad(0, `PWIT_OFF_BLK_STATUS), 8'h01, `PWIT_RESP_OKAY);
        settle;
        `CHK("irq", 1'b0, irq)
        wr(ad(0, `PWIT_OFF_BLK_ENABLE), 8'h00, r);
        ev(7'h0, 7'h0, 7'h0, 1'b1, 3'd5, switch_mac_addr);
        settle;
        `CHK("irq", 1'b0, irq)
        wrap_up;
    end
endmodule // pwit_regs_tb
